//--- design/dpll_lock_pkg.sv
package dpll_lock_pkg;

  // ==========================================================
  // register map (word aligned byte addresses)
  localparam logic [7:0] FB_CORR_ADDR   = 8'h00;
  localparam logic [7:0] LOCK_CFG_ADDR  = 8'h04;
  localparam logic [7:0] STATE_STS_ADDR = 8'h08;
  localparam logic [7:0] EVENT_ADDR     = 8'h0C;

  // ==========================================================
  // feedback correction fields
  localparam int         FB_DIV_OFF_BIT = 15;
  localparam int         FINE_REV_BIT   = 9;
  localparam int         PEC_DELAY_LSB  = 7;
  localparam int         PEC_MULT_LSB   = 0;
  localparam logic [1:0] PEC_DELAY_ONE  = 2'h1;
  localparam int         FINE_W         = 31;
  localparam int         MULT_W         = 7;

  // ==========================================================
  // lock detector fields
  localparam int          LOCK_TIMER_LSB    = 16;
  localparam int          LOCK_THRESH_LSB   = 0;
  localparam logic [15:0] LOCK_TIMER_RESET  = 16'h00FF;
  localparam logic [15:0] LOCK_THRESH_RESET = 16'h0155;
  localparam logic [15:0] LOCK_TIMER_MIN    = 16'h0002;
  localparam int          THRESH_SHIFT      = 3;
  localparam int          PHASE_W           = 30;

  // ==========================================================
  // status and event fields
  localparam int STATE_STS_LSB = 4;
  localparam int REF_SEL_LSB   = 1;
  localparam int LOCK_STS_BIT  = 0;
  localparam int STATE_CH_BIT  = 3;

  localparam logic [2:0] STS_FREERUN   = 3'h0;
  localparam logic [2:0] STS_NORMAL    = 3'h1;
  localparam logic [2:0] STS_HOLDOVER  = 3'h2;
  localparam logic [2:0] STS_WRITE_FRQ = 3'h3;
  localparam logic [2:0] STS_ACQUIRE   = 3'h4;
  localparam logic [2:0] STS_HITLESS   = 3'h5;

  // ==========================================================
  // timing
  localparam int unsigned MS_TIME_NS    = 1000000;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned CYCLES_PER_MS = MS_TIME_NS / CLK_PERIOD_NS;

  typedef enum logic [5:0] {
    ST_FREERUN   = 6'b000001,
    ST_ACQUIRE   = 6'b000010,
    ST_NORMAL    = 6'b000100,
    ST_HOLDOVER  = 6'b001000,
    ST_WRITE_FRQ = 6'b010000,
    ST_HITLESS   = 6'b100000
  } loop_state_type;

endpackage

//--- design/dpll_lock_status_regs.sv
// Function
// - divider off when disabled or loop off
// - fine timestamp bit order straight or reversed
// - delay code one delays error term
// - multiply sdm remainder by correction multiplier
// - acquire to normal after half interval
// - bandwidth switches to normal at that transition
// - lock after further half interval
// - lock timer in ms, reset 0x00FF, min 2
// - threshold in eight tdc steps, reset 0x0155
// - state status field encodes loop state
// - reference selection status shows used input
// - lock status bit reads locked state
// - sticky state change event, write one clears
`timescale 1ns/1ns
`default_nettype none
module dpll_lock_status_regs
  import dpll_lock_pkg::*;
#(
  parameter int unsigned CYCLES_PER_MS_P = CYCLES_PER_MS,
  parameter int          SDM_W           = 16
) (
  input  wire logic                    core_clk_in,
  input  wire logic                    rst_n_in,
  input  wire logic [7:0]              reg_addr_in,
  input  wire logic [31:0]             reg_wdata_in,
  input  wire logic                    reg_wr_in,
  input  wire logic                    reg_rd_in,
  output logic      [31:0]             reg_rdata_out,
  input  wire logic                    loop_enable_in,
  input  wire logic                    tdc_enable_in,
  input  wire logic                    bandwidth_switch_enable_in,
  input  wire logic                    ref_valid_in,
  input  wire logic                    write_frequency_in,
  input  wire logic                    hitless_switch_in,
  input  wire logic [1:0]              selected_ref_in,
  input  wire logic [PHASE_W-1:0]      phase_error_in,
  input  wire logic [FINE_W-1:0]       fine_analog_in,
  input  wire logic [SDM_W-1:0]        sdm_remainder_in,
  output logic                         feedback_divider_enable_out,
  output logic      [FINE_W-1:0]       fine_digital_out,
  output logic      [SDM_W+MULT_W-1:0] sdm_correction_out,
  output logic                         normal_bandwidth_out,
  output logic      [2:0]              loop_state_out,
  output logic                         locked_out
);

  // ==========================================================
  // configuration registers
  logic              feedback_divider_off_ff;
  logic              nxt_feedback_divider_off;
  logic              fine_rev_ff;
  logic              nxt_fine_rev;
  logic [1:0]        pec_delay_ff;
  logic [1:0]        nxt_pec_delay;
  logic [MULT_W-1:0] pec_mult_ff;
  logic [MULT_W-1:0] nxt_pec_mult;
  logic [15:0]       lock_timer_ff;
  logic [15:0]       nxt_lock_timer;
  logic [15:0]       lock_thresh_ff;
  logic [15:0]       nxt_lock_thresh;

  always_comb begin
    nxt_feedback_divider_off = feedback_divider_off_ff;
    nxt_fine_rev             = fine_rev_ff;
    nxt_pec_delay            = pec_delay_ff;
    nxt_pec_mult             = pec_mult_ff;
    nxt_lock_timer           = lock_timer_ff;
    nxt_lock_thresh          = lock_thresh_ff;
    if (reg_wr_in && reg_addr_in == FB_CORR_ADDR) begin
      nxt_feedback_divider_off = reg_wdata_in[FB_DIV_OFF_BIT];
      nxt_fine_rev             = reg_wdata_in[FINE_REV_BIT];
      // taken at any time; quiet results only if tdc is held off meanwhile
      nxt_pec_delay            = reg_wdata_in[PEC_DELAY_LSB +: 2];
      nxt_pec_mult             = reg_wdata_in[PEC_MULT_LSB +: MULT_W];
    end
    if (reg_wr_in && reg_addr_in == LOCK_CFG_ADDR) begin
      nxt_lock_timer  = reg_wdata_in[LOCK_TIMER_LSB +: 16];
      nxt_lock_thresh = reg_wdata_in[LOCK_THRESH_LSB +: 16];
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      feedback_divider_off_ff <= 1'b0;
      fine_rev_ff             <= 1'b0;
      pec_delay_ff            <= 2'h0;
      pec_mult_ff             <= '0;
      lock_timer_ff           <= LOCK_TIMER_RESET;
      lock_thresh_ff          <= LOCK_THRESH_RESET;
    end else begin
      feedback_divider_off_ff <= nxt_feedback_divider_off;
      fine_rev_ff             <= nxt_fine_rev;
      pec_delay_ff            <= nxt_pec_delay;
      pec_mult_ff             <= nxt_pec_mult;
      lock_timer_ff           <= nxt_lock_timer;
      lock_thresh_ff          <= nxt_lock_thresh;
    end
  end

  assign feedback_divider_enable_out = loop_enable_in & ~feedback_divider_off_ff;

  // ==========================================================
  // correction datapath
  fb_correction_path #(
    .SDM_W (SDM_W)
  ) u_corr (
    .core_clk_in      (core_clk_in),
    .rst_n_in         (rst_n_in),
    .sample_en_in     (tdc_enable_in),
    .fine_reverse_in  (fine_rev_ff),
    .delay_sel_in     (pec_delay_ff),
    .mult_in          (pec_mult_ff),
    .fine_analog_in   (fine_analog_in),
    .sdm_remainder_in (sdm_remainder_in),
    .fine_digital_out (fine_digital_out),
    .correction_out   (sdm_correction_out)
  );

  // ==========================================================
  // lock detector measurement
  logic                ms_tick;
  logic [PHASE_W-1:0]  abs_err;
  logic [PHASE_W-1:0]  thresh_scaled;
  logic [15:0]         timer_eff;
  logic [15:0]         half_interval;
  logic                below;
  logic                measuring;
  logic                half_reached;
  logic [15:0]         ms_count_ff;
  logic [15:0]         nxt_ms_count;

  ms_tick_divider #(
    .DIVIDE (CYCLES_PER_MS_P)
  ) u_ms (
    .core_clk_in (core_clk_in),
    .rst_n_in    (rst_n_in),
    .tick_out    (ms_tick)
  );

  loop_state_type state_ff;
  loop_state_type nxt_state;
  logic           locked_ff;
  logic           nxt_locked;

  always_comb begin
    abs_err = phase_error_in[PHASE_W-1] ? PHASE_W'(-phase_error_in) : phase_error_in;
    thresh_scaled = PHASE_W'({lock_thresh_ff, 3'h0});
    below = (abs_err < thresh_scaled);
    // a value under the minimum would make the half interval vanish
    timer_eff = (lock_timer_ff < LOCK_TIMER_MIN) ? LOCK_TIMER_MIN : lock_timer_ff;
    half_interval = {1'b0, timer_eff[15:1]};
    measuring = (state_ff == ST_ACQUIRE) || (state_ff == ST_NORMAL && !locked_ff);
    half_reached = measuring && below && (ms_count_ff >= half_interval);
  end

  // ==========================================================
  // loop state machine
  always_comb begin
    nxt_state = state_ff;
    if (!loop_enable_in) begin
      nxt_state = ST_FREERUN;
    end else begin
      unique case (state_ff)
        ST_FREERUN: begin
          if (write_frequency_in) nxt_state = ST_WRITE_FRQ;
          else if (ref_valid_in) nxt_state = ST_ACQUIRE;
        end
        ST_ACQUIRE: begin
          if (write_frequency_in) nxt_state = ST_WRITE_FRQ;
          else if (!ref_valid_in) nxt_state = ST_HOLDOVER;
          else if (half_reached) nxt_state = ST_NORMAL;
        end
        ST_NORMAL: begin
          if (write_frequency_in) nxt_state = ST_WRITE_FRQ;
          else if (!ref_valid_in) nxt_state = ST_HOLDOVER;
          else if (hitless_switch_in) nxt_state = ST_HITLESS;
        end
        ST_HOLDOVER: begin
          if (write_frequency_in) nxt_state = ST_WRITE_FRQ;
          else if (ref_valid_in) nxt_state = ST_ACQUIRE;
        end
        ST_WRITE_FRQ: begin
          if (!write_frequency_in) nxt_state = ref_valid_in ? ST_ACQUIRE : ST_FREERUN;
        end
        ST_HITLESS: begin
          if (!ref_valid_in) nxt_state = ST_HOLDOVER;
          else if (!hitless_switch_in) nxt_state = ST_NORMAL;
        end
        default: nxt_state = ST_FREERUN;
      endcase
    end
  end

  always_comb begin
    nxt_locked = locked_ff;
    if (nxt_state != ST_NORMAL && nxt_state != ST_HITLESS) begin
      nxt_locked = 1'b0;
    end else if (state_ff == ST_NORMAL && !locked_ff && half_reached) begin
      nxt_locked = 1'b1;
    end else if (state_ff == ST_NORMAL && locked_ff && !below) begin
      // a locked loop in normal whose error leaves the window drops lock and remeasures; in hitless lock is kept
      nxt_locked = 1'b0;
    end
  end

  always_comb begin
    nxt_ms_count = ms_count_ff;
    if (!measuring || !below || half_reached || nxt_state != state_ff) begin
      nxt_ms_count = 16'h0000;
    end else if (ms_tick && ms_count_ff != 16'hFFFF) begin
      nxt_ms_count = ms_count_ff + 16'h0001;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_ff    <= ST_FREERUN;
      locked_ff   <= 1'b0;
      ms_count_ff <= 16'h0000;
    end else begin
      state_ff    <= nxt_state;
      locked_ff   <= nxt_locked;
      ms_count_ff <= nxt_ms_count;
    end
  end

  // ==========================================================
  // status encoding and event flag
  logic [2:0] state_code;
  logic [1:0] ref_sel_ff;
  logic       state_changed_event_ff;
  logic       nxt_state_changed_event;
  logic       nrm_bw_ff;
  logic       nxt_nrm_bw;

  always_comb begin
    unique case (state_ff)
      ST_FREERUN:   state_code = STS_FREERUN;
      ST_ACQUIRE:   state_code = STS_ACQUIRE;
      ST_NORMAL:    state_code = STS_NORMAL;
      ST_HOLDOVER:  state_code = STS_HOLDOVER;
      ST_WRITE_FRQ: state_code = STS_WRITE_FRQ;
      ST_HITLESS:   state_code = STS_HITLESS;
      default:      state_code = STS_FREERUN;
    endcase
  end

  always_comb begin
    nxt_state_changed_event = state_changed_event_ff;
    if (reg_wr_in && reg_addr_in == EVENT_ADDR && reg_wdata_in[STATE_CH_BIT]) begin
      nxt_state_changed_event = 1'b0;
    end
    // a transition in the clearing cycle is kept
    if (nxt_state != state_ff) begin
      nxt_state_changed_event = 1'b1;
    end
    nxt_nrm_bw = bandwidth_switch_enable_in &&
                 (nxt_state == ST_NORMAL || nxt_state == ST_HITLESS);
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_changed_event_ff <= 1'b0;
      ref_sel_ff             <= 2'h0;
      nrm_bw_ff              <= 1'b0;
    end else begin
      state_changed_event_ff <= nxt_state_changed_event;
      ref_sel_ff             <= selected_ref_in;
      nrm_bw_ff              <= nxt_nrm_bw;
    end
  end

  assign normal_bandwidth_out = nrm_bw_ff;
  assign loop_state_out       = state_code;
  assign locked_out           = locked_ff;

  // ==========================================================
  // read port: data stand one cycle after the strobe, zero otherwise
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;

  always_comb begin
    nxt_rdata = 32'h0000_0000;
    if (reg_rd_in) begin
      unique case (reg_addr_in)
        FB_CORR_ADDR: begin
          nxt_rdata[FB_DIV_OFF_BIT]             = feedback_divider_off_ff;
          nxt_rdata[FINE_REV_BIT]               = fine_rev_ff;
          nxt_rdata[PEC_DELAY_LSB +: 2]         = pec_delay_ff;
          nxt_rdata[PEC_MULT_LSB +: MULT_W]     = pec_mult_ff;
        end
        LOCK_CFG_ADDR: begin
          nxt_rdata[LOCK_TIMER_LSB +: 16]       = lock_timer_ff;
          nxt_rdata[LOCK_THRESH_LSB +: 16]      = lock_thresh_ff;
        end
        STATE_STS_ADDR: begin
          nxt_rdata[STATE_STS_LSB +: 3]         = state_code;
          nxt_rdata[REF_SEL_LSB +: 2]           = ref_sel_ff;
          nxt_rdata[LOCK_STS_BIT]               = locked_ff;
        end
        EVENT_ADDR: begin
          nxt_rdata[STATE_CH_BIT]               = state_changed_event_ff;
        end
        default: nxt_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_ff <= 32'h0000_0000;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata_out = rdata_ff;

endmodule
`default_nettype wire

//--- design/fb_correction_path.sv
`timescale 1ns/1ns
`default_nettype none
module fb_correction_path
  import dpll_lock_pkg::*;
#(
  parameter int SDM_W = 16
) (
  input  wire logic                    core_clk_in,
  input  wire logic                    rst_n_in,
  input  wire logic                    sample_en_in,
  input  wire logic                    fine_reverse_in,
  input  wire logic [1:0]              delay_sel_in,
  input  wire logic [MULT_W-1:0]       mult_in,
  input  wire logic [FINE_W-1:0]       fine_analog_in,
  input  wire logic [SDM_W-1:0]        sdm_remainder_in,
  output logic      [FINE_W-1:0]       fine_digital_out,
  output logic      [SDM_W+MULT_W-1:0] correction_out
);

  logic [FINE_W-1:0]       fine_ff;
  logic [FINE_W-1:0]       nxt_fine;
  logic [SDM_W-1:0]        sdm_dly_ff;
  logic [SDM_W-1:0]        nxt_sdm_dly;
  logic [SDM_W+MULT_W-1:0] corr_ff;
  logic [SDM_W+MULT_W-1:0] nxt_corr;
  logic [SDM_W-1:0]        sdm_sel;

  always_comb begin
    nxt_fine = fine_analog_in;
    if (fine_reverse_in) begin
      for (int i = 0; i < FINE_W; i++) begin
        nxt_fine[i] = fine_analog_in[FINE_W-1-i];
      end
    end
    nxt_sdm_dly = sample_en_in ? sdm_remainder_in : sdm_dly_ff;
    // only the code one adds a stage; the other three codes pass straight
    sdm_sel  = (delay_sel_in == PEC_DELAY_ONE) ? sdm_dly_ff : sdm_remainder_in;
    // both operands widened first so the product keeps its upper bits
    nxt_corr = sample_en_in ? (SDM_W+MULT_W)'(sdm_sel) * (SDM_W+MULT_W)'(mult_in) : corr_ff;
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      fine_ff    <= '0;
      sdm_dly_ff <= '0;
      corr_ff    <= '0;
    end else begin
      fine_ff    <= nxt_fine;
      sdm_dly_ff <= nxt_sdm_dly;
      corr_ff    <= nxt_corr;
    end
  end

  assign fine_digital_out = fine_ff;
  assign correction_out   = corr_ff;

endmodule
`default_nettype wire

//--- design/ms_tick_divider.sv
`timescale 1ns/1ns
`default_nettype none
module ms_tick_divider
  import dpll_lock_pkg::*;
#(
  parameter int unsigned DIVIDE = CYCLES_PER_MS
) (
  input  wire logic core_clk_in,
  input  wire logic rst_n_in,
  output logic      tick_out
);

  localparam int CNT_W = $clog2(DIVIDE + 1);
  localparam logic [CNT_W-1:0] LAST = CNT_W'(DIVIDE - 1);

  logic [CNT_W-1:0] count_ff;
  logic [CNT_W-1:0] nxt_count;
  logic             tick_ff;
  logic             nxt_tick;

  always_comb begin
    nxt_tick  = (count_ff == LAST);
    nxt_count = nxt_tick ? '0 : count_ff + CNT_W'(1);
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      count_ff <= '0;
      tick_ff  <= 1'b0;
    end else begin
      count_ff <= nxt_count;
      tick_ff  <= nxt_tick;
    end
  end

  assign tick_out = tick_ff;

endmodule
`default_nettype wire

//--- verification/dpll_lock_status_regs_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module dpll_lock_status_regs_assertions
  import dpll_lock_pkg::*;
#(
  parameter int SDM_W = 16
) (
  input  wire logic                    core_clk_in,
  input  wire logic                    rst_n_in,
  input  wire logic [7:0]              reg_addr_in,
  input  wire logic [31:0]             reg_wdata_in,
  input  wire logic                    reg_wr_in,
  input  wire logic                    loop_enable_in,
  input  wire logic                    tdc_enable_in,
  input  wire logic                    bandwidth_switch_enable_in,
  input  wire logic [FINE_W-1:0]       fine_analog_in,
  input  wire logic [SDM_W-1:0]        sdm_remainder_in,
  input  wire logic                    feedback_divider_enable_out,
  input  wire logic [FINE_W-1:0]       fine_digital_out,
  input  wire logic [SDM_W+MULT_W-1:0] sdm_correction_out,
  input  wire logic                    normal_bandwidth_out,
  input  wire logic [2:0]              loop_state_out,
  input  wire logic                    locked_out
);
  localparam int CW = SDM_W + MULT_W;
  // ==========================================================
  // shadow of the correction register, rebuilt from bus writes
  logic [15:0]       fb_ff;
  logic [15:0]       nxt_fb;
  logic              up_ff;
  logic [FINE_W-1:0] rev_w;
  always_comb begin
    nxt_fb = fb_ff;
    if (reg_wr_in && reg_addr_in == FB_CORR_ADDR) begin
      nxt_fb = reg_wdata_in[15:0];
    end
    for (int i = 0; i < FINE_W; i++) begin
      rev_w[i] = fine_analog_in[FINE_W-1-i];
    end
  end
  // up_ff masks the first edge, where past values still come from reset
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      fb_ff <= 16'h0000;
      up_ff <= 1'b0;
    end else begin
      fb_ff <= nxt_fb;
      up_ff <= 1'b1;
    end
  end
  // ==========================================================
  // properties
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  AST_DIV: assert property (feedback_divider_enable_out == (loop_enable_in && !fb_ff[FB_DIV_OFF_BIT]))
    else $error("divider enable does not follow loop enable and off bit");
  AST_FINE: assert property (up_ff |=> fine_digital_out ==
    ($past(fb_ff[FINE_REV_BIT]) ? $past(rev_w) : $past(fine_analog_in)))
    else $error("fine timestamp order wrong");
  AST_MULT: assert property (up_ff && tdc_enable_in && fb_ff[8:7] != PEC_DELAY_ONE |=>
    sdm_correction_out == CW'($past(sdm_remainder_in)) * $past(fb_ff[6:0]))
    else $error("correction product wrong without delay");
  AST_DELAY: assert property (up_ff && tdc_enable_in && fb_ff[8:7] == PEC_DELAY_ONE ##1
    tdc_enable_in && fb_ff[8:7] == PEC_DELAY_ONE |=>
    sdm_correction_out == CW'($past(sdm_remainder_in, 2)) * $past(fb_ff[6:0]))
    else $error("correction product wrong with one cycle delay");
  AST_HOLD: assert property (!tdc_enable_in |=> $stable(sdm_correction_out))
    else $error("correction moved while tdc off");
  AST_FREERUN: assert property (!loop_enable_in ##1 !loop_enable_in |->
    loop_state_out == STS_FREERUN)
    else $error("loop off but state not freerun");
  AST_BW_ACQ: assert property (loop_state_out == STS_ACQUIRE [*2] |-> !normal_bandwidth_out)
    else $error("normal bandwidth in acquire");
  AST_BW_NORM: assert property ((loop_state_out == STS_NORMAL && bandwidth_switch_enable_in) [*2]
    |-> normal_bandwidth_out)
    else $error("acquire bandwidth kept in normal");
  AST_ENTRY: assert property (loop_state_out == STS_ACQUIRE ##1 loop_state_out == STS_NORMAL
    |-> !locked_out [*8])
    else $error("lock declared too soon after entering normal");
endmodule
`default_nettype wire

//--- verification/dpll_lock_status_regs_tb.sv
`timescale 1ns/1ns
`default_nettype none
module dpll_lock_status_regs_tb
  import dpll_lock_pkg::*;
;
  logic        core_clk_in, rst_n_in, reg_wr_in, reg_rd_in, loop_enable_in, tdc_enable_in;
  logic        bandwidth_switch_enable_in, ref_valid_in, wr_frq, hitless;
  logic [7:0]  reg_addr_in;
  logic [31:0] reg_wdata_in, reg_rdata_out;
  logic [1:0]  selected_ref_in;
  logic [29:0] phase_error_in;
  logic [30:0] fine_analog_in, fine_digital_out;
  logic [15:0] sdm_remainder_in;
  logic [22:0] sdm_correction_out;
  logic        div_en, normal_bw, locked_out;
  logic [2:0]  loop_state_out;
  int          miscompares, n_checks, n;
  localparam logic [29:0] BELOW = 30'h3FFF_FF9C;
  typedef struct packed { logic [7:0] a; logic [31:0] d; logic [31:0] e; } row_type;
  row_type rows [5] = '{
    '{FB_CORR_ADDR,   32'hFFFF_FFFF, 32'h0000_83FF},
    '{LOCK_CFG_ADDR,  32'h1234_5678, 32'h1234_5678},
    '{STATE_STS_ADDR, 32'hFFFF_FFFF, 32'h0000_0006},
    '{EVENT_ADDR,     32'hFFFF_FFFF, 32'h0000_0000},
    '{8'h10,          32'hFFFF_FFFF, 32'h0000_0000}};
  dpll_lock_status_regs #(.CYCLES_PER_MS_P(10), .SDM_W(16)) dut_u (
    .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .loop_enable_in(loop_enable_in),
    .tdc_enable_in(tdc_enable_in), .bandwidth_switch_enable_in(bandwidth_switch_enable_in),
    .ref_valid_in(ref_valid_in), .write_frequency_in(wr_frq), .hitless_switch_in(hitless),
    .selected_ref_in(selected_ref_in), .phase_error_in(phase_error_in),
    .fine_analog_in(fine_analog_in), .sdm_remainder_in(sdm_remainder_in),
    .feedback_divider_enable_out(div_en), .fine_digital_out(fine_digital_out),
    .sdm_correction_out(sdm_correction_out), .normal_bandwidth_out(normal_bw),
    .loop_state_out(loop_state_out), .locked_out(locked_out));
  // ==========================================================
  // shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic step();
    @(posedge core_clk_in);
    @(negedge core_clk_in);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge core_clk_in);
    reg_wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge core_clk_in);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge core_clk_in);
    reg_rd_in <= 1'b0;
    @(negedge core_clk_in);
    chk(reg_rdata_out, e);
  endtask
  // waits for {locked, state}; a hang here is a mismatch
  task automatic wait_st(input logic [3:0] want);
    n = 0;
    while ({locked_out, loop_state_out} !== want && n < 300) begin
      @(negedge core_clk_in);
      n++;
    end
    if (n >= 300) begin
      miscompares++;
      $display("BAD %0t wait timed out", $time);
      results();
    end
  endtask
  initial begin
    core_clk_in = 1'b0;
    forever #5 core_clk_in = ~core_clk_in;
  end
  // ==========================================================
  // main sequence
  initial begin
    {rst_n_in, reg_wr_in, reg_rd_in, loop_enable_in, tdc_enable_in, wr_frq, hitless} = '0;
    {bandwidth_switch_enable_in, ref_valid_in} = 2'h3;
    {reg_addr_in, reg_wdata_in, sdm_remainder_in, fine_analog_in} = '0;
    {miscompares, n_checks} = '0;
    selected_ref_in = 2'h3;
    phase_error_in = 30'h0000_0080;
    repeat (16) @(posedge core_clk_in);
    rst_n_in <= 1'b1;
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rows[i].e);
    end
    wr(FB_CORR_ADDR, 32'h0000_0200);
    fine_analog_in <= 31'h0000_0003;
    step();
    chk(fine_digital_out, 32'h6000_0000);
    wr(FB_CORR_ADDR, 32'h0000_8000);
    loop_enable_in <= 1'b1;
    step();
    chk(fine_digital_out, 32'h0000_0003);
    chk(div_en, 32'h0);
    wr(FB_CORR_ADDR, 32'h0000_0005);
    tdc_enable_in <= 1'b1;
    sdm_remainder_in <= 16'h0100;
    step();
    chk(div_en, 32'h1);
    step();
    chk(sdm_correction_out, 32'h0000_0500);
    @(posedge core_clk_in);
    tdc_enable_in <= 1'b0;
    wr(FB_CORR_ADDR, 32'h0000_0085);
    tdc_enable_in <= 1'b1;
    repeat (3) step();
    @(posedge core_clk_in);
    sdm_remainder_in <= 16'h0200;
    step();
    chk(sdm_correction_out, 32'h0000_0500);
    step();
    chk(sdm_correction_out, 32'h0000_0A00);
    // timer 4 ms gives two ticks per half; an error of exactly the threshold, 128 steps, is not below
    wr(LOCK_CFG_ADDR, 32'h0004_0010);
    wait_st({1'b0, STS_ACQUIRE});
    repeat (60) step();
    chk(loop_state_out, STS_ACQUIRE);
    chk(normal_bw, 32'h0);
    @(posedge core_clk_in);
    phase_error_in <= BELOW;
    wait_st({1'b0, STS_NORMAL});
    chk(n > 10 && n < 23, 32'h1);
    step();
    chk(normal_bw, 32'h1);
    @(posedge core_clk_in);
    phase_error_in <= 30'h0000_0080;
    repeat (15) step();
    chk(locked_out, 32'h0);
    @(posedge core_clk_in);
    phase_error_in <= BELOW;
    wait_st({1'b1, STS_NORMAL});
    chk(n > 10 && n < 23, 32'h1);
    rd(STATE_STS_ADDR, 32'h0000_0017);
    rd(EVENT_ADDR, 32'h0000_0008);
    wr(EVENT_ADDR, 32'h0000_0000);
    rd(EVENT_ADDR, 32'h0000_0008);
    wr(EVENT_ADDR, 32'h0000_0008);
    rd(EVENT_ADDR, 32'h0000_0000);
    @(posedge core_clk_in);
    loop_enable_in <= 1'b0;
    wait_st({1'b0, STS_FREERUN});
    chk(div_en, 32'h0);
    rd(EVENT_ADDR, 32'h0000_0008);
    rd(STATE_STS_ADDR, 32'h0000_0006);
    // remaining state codes from the level inputs; bandwidth switch left off
    @(posedge core_clk_in);
    {loop_enable_in, wr_frq, bandwidth_switch_enable_in} <= 3'h6;
    wait_st({1'b0, STS_WRITE_FRQ});
    rd(STATE_STS_ADDR, 32'h0000_0036);
    @(posedge core_clk_in);
    wr_frq <= 1'b0;
    wait_st({1'b0, STS_NORMAL});
    chk(normal_bw, 32'h0);
    @(posedge core_clk_in);
    hitless <= 1'b1;
    wait_st({1'b0, STS_HITLESS});
    rd(STATE_STS_ADDR, 32'h0000_0056);
    @(posedge core_clk_in);
    ref_valid_in <= 1'b0;
    wait_st({1'b0, STS_HOLDOVER});
    rd(STATE_STS_ADDR, 32'h0000_0026);
    @(posedge core_clk_in);
    {loop_enable_in, hitless} <= 2'h0;
    // second reset in mid-run brings every register back
    @(posedge core_clk_in);
    rst_n_in <= 1'b0;
    selected_ref_in <= 2'h0;
    repeat (3) @(posedge core_clk_in);
    rst_n_in <= 1'b1;
    rd(FB_CORR_ADDR, 32'h0000_0000);
    rd(LOCK_CFG_ADDR, 32'h00FF_0155);
    rd(STATE_STS_ADDR, 32'h0000_0000);
    rd(EVENT_ADDR, 32'h0000_0000);
    results();
  end
endmodule
bind dpll_lock_status_regs dpll_lock_status_regs_assertions #(.SDM_W(SDM_W)) chk_u (
  .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .loop_enable_in(loop_enable_in),
  .tdc_enable_in(tdc_enable_in), .bandwidth_switch_enable_in(bandwidth_switch_enable_in),
  .fine_analog_in(fine_analog_in), .sdm_remainder_in(sdm_remainder_in),
  .feedback_divider_enable_out(feedback_divider_enable_out),
  .fine_digital_out(fine_digital_out), .sdm_correction_out(sdm_correction_out),
  .normal_bandwidth_out(normal_bandwidth_out), .loop_state_out(loop_state_out),
  .locked_out(locked_out));
`default_nettype wire
